// ==== rtl/sshp_defs.svh ====
// constants of the serial host port: timing counts and frame figures
// assumes inclusion by bare name from the design modules and the bench
`ifndef SSHP_DEFS_SVH
`define SSHP_DEFS_SVH

// ********************************************************************
// clock rate and link figures
// ********************************************************************
`define SSHP_CLK_MHZ 40
`define SSHP_BYTE_BITS 8
`define SSHP_DETECT_PULSES 4'h8
`define SSHP_BIT_CNT_LAST 3'h7

// ********************************************************************
// detection toggle of the data pending output
// ********************************************************************
`define SSHP_TOGGLE_NS 100000
`define SSHP_TOGGLE_CYC ((`SSHP_TOGGLE_NS * `SSHP_CLK_MHZ) / 1000)

// ********************************************************************
// reset values and the idle transmit byte
// ********************************************************************
`define SSHP_SYNC_RST 1'b1
`define SSHP_BYTE_RST 8'h00
`define SSHP_TX_IDLE_BYTE 8'h00

`endif

// ==== rtl/sshp_pkg.sv ====
// types of the serial host port
// assumes sshp_defs.svh is reachable on the include path
`default_nettype none
package sshp_pkg;

  // ******************************************************************
  // port mode: gray codes along detect, active, off
  // ******************************************************************
  typedef enum logic [1:0] {
    SSHP_DETECT = 2'b00,
    SSHP_ACTIVE = 2'b01,
    SSHP_OFF = 2'b11
  } sshp_mode_t;

  typedef logic [7:0] sshp_byte_t;

endpackage
`default_nettype wire

// ==== rtl/sshp_shift.sv ====
// byte shifter of the serial host port
// assumes lead and trail are one-cycle strobes from the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
`include "sshp_defs.svh"

module sshp_shift (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic frame_idle, // chip select released
  input wire logic lead, // leading serial clock edge
  input wire logic trail, // trailing serial clock edge
  input wire logic mosi_bit, // synchronised data in
  input wire sshp_pkg::sshp_byte_t tx_data, // next byte to send
  input wire logic tx_valid, // tx_data holds a byte
  output logic tx_take, // byte taken this cycle
  output sshp_pkg::sshp_byte_t rx_data, // last byte received
  output logic rx_strobe, // rx_data updated, one cycle
  output logic miso // serial data out
);
  import sshp_pkg::*;

  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  sshp_byte_t tx_shift;
  sshp_byte_t next_tx_shift;
  sshp_byte_t rx_shift;
  sshp_byte_t next_rx_shift;
  sshp_byte_t next_rx_data;
  logic next_rx_strobe;
  logic next_miso;
  sshp_byte_t load;

  // a new byte is fetched on the first leading edge of each byte
  assign tx_take = lead & (bit_cnt == 3'h0) & tx_valid;
  assign load = tx_valid ? tx_data : `SSHP_TX_IDLE_BYTE;

  // launch on leading edge, sample on trailing edge, msb first
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_rx_data = rx_data;
    next_rx_strobe = 1'b0;
    next_miso = miso;
    if (frame_idle) begin
      next_bit_cnt = 3'h0;
    end else if (lead) begin
      if (bit_cnt == 3'h0) begin
        next_miso = load[7];
        next_tx_shift = {load[6:0], 1'b0};
      end else begin
        next_miso = tx_shift[7];
        next_tx_shift = {tx_shift[6:0], 1'b0};
      end
    end else if (trail) begin
      next_rx_shift = {rx_shift[6:0], mosi_bit};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == `SSHP_BIT_CNT_LAST) begin
        next_rx_data = {rx_shift[6:0], mosi_bit};
        next_rx_strobe = 1'b1;
      end
    end
  end

  // shifter registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bit_cnt <= 3'h0;
      tx_shift <= `SSHP_BYTE_RST;
      rx_shift <= `SSHP_BYTE_RST;
      rx_data <= `SSHP_BYTE_RST;
      rx_strobe <= 1'b0;
      miso <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      rx_data <= next_rx_data;
      rx_strobe <= next_rx_strobe;
      miso <= next_miso;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/sshp_top.sv ====
// serial host port of the module: slave end of a four-wire serial link
// assumes the link pins are asynchronous to clk_sys and the user side
// logic runs on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "sshp_defs.svh"

module sshp_top (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic spi_sclk, // serial clock from the master
  input wire logic spi_cs_n, // chip select, active low
  input wire logic spi_mosi, // serial data in
  output logic spi_miso, // serial data out
  output logic spi_miso_oe_n, // low while miso is driven
  output logic data_pending_out, // data ready for the master
  output logic receive_full_out, // no room for more data
  input wire logic pending_disable, // turns the pending output off
  input wire logic full_enable, // turns the full output on
  input wire logic uart_cmd_seen, // command seen on the uart, pulse
  input wire logic rx_busy, // user side cannot take bytes
  input wire sshp_pkg::sshp_byte_t tx_data, // byte to send
  input wire logic tx_valid, // tx_data holds a byte
  output logic tx_ready, // tx_data taken this cycle
  output sshp_pkg::sshp_byte_t rx_data, // byte received
  output logic rx_valid, // rx_data new, one cycle
  output sshp_pkg::sshp_mode_t port_mode, // detect, active or off
  output logic frame_active // chip select seen asserted
);
  import sshp_pkg::*;

  // ******************************************************************
  // pin synchronisers
  // ******************************************************************
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_d;
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic mosi_s1;
  logic mosi_s2;

  // two stages per pin, then one more on sclk and cs for edge finding
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      cs_s1 <= `SSHP_SYNC_RST;
      cs_s2 <= `SSHP_SYNC_RST;
      cs_d <= `SSHP_SYNC_RST;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  // ******************************************************************
  // frame and edge decode
  // ******************************************************************
  logic cs_act;
  logic frame_start;
  logic sclk_edge;
  logic idle_lvl;
  logic next_idle_lvl;
  logic lead;
  logic trail;

  // clock and data count only while chip select is asserted
  assign cs_act = ~cs_s2;
  assign frame_start = cs_act & cs_d;
  assign sclk_edge = sclk_s2 ^ sclk_d;
  // the idle level at frame start tells mode 1 from mode 3
  assign lead = cs_act & ~frame_start & sclk_edge & (sclk_d == idle_lvl);
  assign trail = cs_act & ~frame_start & sclk_edge & (sclk_d != idle_lvl);
  assign frame_active = cs_act;

  // idle level capture
  always_comb begin
    next_idle_lvl = idle_lvl;
    if (frame_start) begin
      next_idle_lvl = sclk_s2;
    end
  end

  // idle level register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      idle_lvl <= 1'b0;
    end else begin
      idle_lvl <= next_idle_lvl;
    end
  end

  // ******************************************************************
  // interface detection
  // ******************************************************************
  sshp_mode_t mode;
  sshp_mode_t next_mode;
  logic [3:0] det_cnt;
  logic [3:0] next_det_cnt;
  logic [11:0] tog_cnt;
  logic [11:0] next_tog_cnt;
  logic tog_lvl;
  logic next_tog_lvl;

  assign port_mode = mode;

  // detection counts serial clock pulses and toggles the pending line
  always_comb begin
    next_mode = mode;
    next_det_cnt = det_cnt;
    next_tog_cnt = tog_cnt;
    next_tog_lvl = tog_lvl;
    unique case (mode)
      SSHP_DETECT: begin
        if (tog_cnt == 12'((`SSHP_TOGGLE_CYC) - 1)) begin
          next_tog_cnt = 12'h000;
          next_tog_lvl = ~tog_lvl;
        end else begin
          next_tog_cnt = tog_cnt + 12'h001;
        end
        if (uart_cmd_seen) begin
          next_mode = SSHP_OFF;
        end else if (lead) begin
          next_det_cnt = det_cnt + 4'h1;
          if (det_cnt == `SSHP_DETECT_PULSES - 4'h1) begin
            next_mode = SSHP_ACTIVE;
          end
        end
      end
      SSHP_ACTIVE: begin
        next_tog_lvl = 1'b0;
      end
      SSHP_OFF: begin
        next_tog_lvl = 1'b0;
      end
      default: begin
        next_mode = SSHP_OFF;
      end
    endcase
  end

  // detection registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode <= SSHP_DETECT;
      det_cnt <= 4'h0;
      tog_cnt <= 12'h000;
      tog_lvl <= 1'b0;
    end else begin
      mode <= next_mode;
      det_cnt <= next_det_cnt;
      tog_cnt <= next_tog_cnt;
      tog_lvl <= next_tog_lvl;
    end
  end

  // ******************************************************************
  // byte shifter, slave side only
  // ******************************************************************
  logic link_on;
  logic rx_strobe;

  // the master owns the clock; this end never drives it
  assign link_on = (mode == SSHP_ACTIVE);

  sshp_shift u_shift (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .frame_idle(~cs_act),
    .lead(lead & link_on),
    .trail(trail & link_on),
    .mosi_bit(mosi_s2),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_take(tx_ready),
    .rx_data(rx_data),
    .rx_strobe(rx_strobe),
    .miso(spi_miso)
  );

  assign rx_valid = rx_strobe;

  // ******************************************************************
  // status outputs
  // ******************************************************************
  logic next_pending;
  logic next_full;
  logic next_oe_n;

  // pending shows the detect toggle, then waiting tx bytes
  always_comb begin
    next_pending = 1'b0;
    if (pending_disable) begin
      next_pending = 1'b0;
    end else if (mode == SSHP_DETECT) begin
      next_pending = tog_lvl;
    end else if (mode == SSHP_ACTIVE) begin
      next_pending = tx_valid;
    end
    next_full = full_enable & link_on & rx_busy;
    next_oe_n = ~(cs_act & link_on);
  end

  // status registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      data_pending_out <= 1'b0;
      receive_full_out <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      data_pending_out <= next_pending;
      receive_full_out <= next_full;
      spi_miso_oe_n <= next_oe_n;
    end
  end

endmodule
`default_nettype wire

// ==== verif/sshp_checker.sv ====
// checker of the serial host port, watching the ports of sshp_top
// assumes one clk_sys domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module sshp_checker (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // reset, active low
  input wire logic spi_miso_oe_n, // low while miso driven
  input wire logic data_pending_out, // pending flag
  input wire logic receive_full_out, // full flag
  input wire logic pending_disable, // pending off
  input wire logic full_enable, // full on
  input wire logic uart_cmd_seen, // uart command pulse
  input wire logic rx_busy, // user side full
  input wire logic tx_valid, // byte offered
  input wire logic tx_ready, // byte taken
  input wire logic rx_valid, // byte received
  input wire sshp_pkg::sshp_mode_t port_mode // port mode
);
  import sshp_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // *********
  // properties
  // *********
  sequence s_uart_in_detect;
    port_mode == SSHP_DETECT && uart_cmd_seen;
  endsequence
  sequence s_pending_live;
    port_mode == SSHP_ACTIVE && !pending_disable;
  endsequence
  a_uart_port_off: assert property (
    s_uart_in_detect |=> port_mode == SSHP_OFF)
    else $error("uart command left port on");
  a_off_stays_off: assert property (
    port_mode == SSHP_OFF |=> port_mode == SSHP_OFF)
    else $error("port left off mode");
  a_off_is_quiet: assert property (
    $past(port_mode) == SSHP_OFF |-> !data_pending_out && spi_miso_oe_n)
    else $error("off port still signals");
  a_miso_needs_active: assert property (
    !spi_miso_oe_n |-> port_mode == SSHP_ACTIVE)
    else $error("miso driven outside active mode");
  a_pending_follows_tx: assert property (
    s_pending_live ##1 s_pending_live |-> data_pending_out == $past(tx_valid))
    else $error("pending does not follow offered byte");
  a_pending_off_cfg: assert property (
    pending_disable [*2] |-> !data_pending_out)
    else $error("pending shown while disabled");
  a_full_follows_busy: assert property (
    full_enable && rx_busy && port_mode == SSHP_ACTIVE |=> receive_full_out)
    else $error("full not shown while busy");
  a_full_off_default: assert property (
    !$past(full_enable) |-> !receive_full_out)
    else $error("full shown while not enabled");
  a_take_when_offered: assert property (
    tx_ready |-> tx_valid && port_mode == SSHP_ACTIVE)
    else $error("byte taken without offer");
  a_rx_single_pulse: assert property (
    rx_valid |=> !rx_valid [*2])
    else $error("receive strobe too long");
endmodule

bind sshp_top sshp_checker u_checker (.clk_sys, .reset_n, .spi_miso_oe_n,
  .data_pending_out, .receive_full_out, .pending_disable, .full_enable,
  .uart_cmd_seen, .rx_busy, .tx_valid, .tx_ready, .rx_valid, .port_mode);
`default_nettype wire

// ==== verif/sshp_master.sv ====
// master model of the serial link, stepping on clk_sys falling edges
// assumes a pull-up on miso while the port releases it
`timescale 1ns/1ps
`default_nettype none

module sshp_master (
  input wire logic clk_sys, // timing reference
  input wire logic spi_miso, // port data out
  input wire logic spi_miso_oe_n, // low while port drives
  output logic spi_sclk, // serial clock
  output logic spi_cs_n, // chip select, active low
  output logic spi_mosi // port data in
);
  logic idle = 1'b0;
  logic wire_miso;
  // released pin reads high through its pull-up
  assign wire_miso = spi_miso_oe_n ? 1'b1 : spi_miso;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // half period of 100 ns, clock at 5 MHz
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // idle level before select picks mode 1 or 3
  task automatic open_frame(input logic mode3);
    idle = mode3;
    spi_sclk = mode3;
    half();
    spi_cs_n = 1'b0;
    half();
  endtask
  // one byte msb first, launch on lead, sample on trail
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_sclk = ~idle;
      spi_mosi = tx[i];
      half();
      spi_sclk = idle;
      rx[i] = wire_miso;
      half();
    end
  endtask
  // release select; mosi no longer holds its last bit
  task automatic close_frame();
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    half();
  endtask
  // clock pulses with select released
  task automatic loose(input int n);
    repeat (n) begin
      spi_sclk = ~idle;
      half();
      spi_sclk = idle;
      half();
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench of the serial host port
// assumes sshp_master as link partner and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "sshp_defs.svh"

module tb_top;
  import sshp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n, pending_disable, full_enable, uart_cmd_seen, rx_busy;
  logic tx_valid, tx_ready, rx_valid, frame_active;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic data_pending_out, receive_full_out;
  sshp_byte_t tx_data, rx_data, got;
  sshp_mode_t port_mode;
  sshp_byte_t rxq[$];
  int err_count = 0;
  int cmp_count = 0;
  int take_count = 0;
  // *********
  // clock, design and partner
  // *********
  always #12.5 clk_sys = ~clk_sys;
  sshp_top u_dut (.clk_sys, .reset_n, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe_n, .data_pending_out, .receive_full_out,
    .pending_disable, .full_enable, .uart_cmd_seen, .rx_busy, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .port_mode, .frame_active);
  sshp_master u_master (.clk_sys, .spi_miso, .spi_miso_oe_n, .spi_sclk,
    .spi_cs_n, .spi_mosi);
  // collect received bytes and count bytes taken for sending
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
    if (tx_ready === 1'b1) begin
      take_count++;
    end
  end
  // *********
  // helpers
  // *********
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // bounded wait for the pending toggle of detection
  task automatic wait_pend();
    int n;
    n = 0;
    while (data_pending_out !== 1'b1 && n < `SSHP_TOGGLE_CYC + 20) begin
      cyc(1);
      n++;
    end
    chk(8'(data_pending_out), 8'h01, "no pending toggle");
    if (n >= `SSHP_TOGGLE_CYC + 20) begin
      end_sim();
    end
  endtask
  // eight-byte frame, optionally judging bytes from the port
  task automatic frame(input logic m3, input sshp_byte_t base,
    input sshp_byte_t exp_out, input logic judge);
    u_master.open_frame(m3);
    chk(8'(frame_active), 8'h01, "select not seen");
    for (int i = 0; i < 8; i++) begin
      u_master.xfer(base + 8'(i), got);
      if (judge) begin
        chk(got, exp_out, "miso byte");
      end
    end
    u_master.close_frame();
    chk(8'(frame_active), 8'h00, "select still seen");
  endtask
  // *********
  // scenarios
  // *********
  task automatic t_detect();
    chk(8'(port_mode), 8'(SSHP_DETECT), "mode after reset");
    chk(8'(receive_full_out), 8'h00, "full default");
    wait_pend();
    u_master.loose(8);
    cyc(8);
    chk(8'(port_mode), 8'(SSHP_DETECT), "unselected clock");
    frame(1'b0, 8'h00, 8'h00, 1'b0);
    cyc(4);
    chk(8'(port_mode), 8'(SSHP_ACTIVE), "not activated");
  endtask
  task automatic t_data(input logic m3, input sshp_byte_t val);
    tx_data = val;
    tx_valid = 1'b1;
    rxq.delete();
    take_count = 0;
    frame(m3, ~val, val, 1'b1);
    cyc(8);
    chk(8'(rxq.size()), 8'h08, "byte count");
    chk(8'(take_count), 8'h08, "take count");
    for (int i = 0; i < rxq.size(); i++) begin
      chk(rxq[i], ~val + 8'(i), "mosi byte");
    end
  endtask
  task automatic t_flags();
    cyc(3);
    chk(8'(data_pending_out), 8'h01, "pending on");
    pending_disable = 1'b1;
    cyc(3);
    chk(8'(data_pending_out), 8'h00, "pending off");
    tx_valid = 1'b0;
    pending_disable = 1'b0;
    rx_busy = 1'b1;
    cyc(3);
    chk(8'(data_pending_out), 8'h00, "pending idle");
    chk(8'(receive_full_out), 8'h00, "full unset");
    full_enable = 1'b1;
    cyc(3);
    chk(8'(receive_full_out), 8'h01, "full on");
    rx_busy = 1'b0;
    cyc(3);
    chk(8'(receive_full_out), 8'h00, "full off");
  endtask
  task automatic t_uart();
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    wait_pend();
    uart_cmd_seen = 1'b1;
    cyc(1);
    uart_cmd_seen = 1'b0;
    cyc(3);
    chk(8'(port_mode), 8'(SSHP_OFF), "uart off");
    chk(8'(data_pending_out), 8'h00, "toggle stop");
    frame(1'b0, 8'h33, 8'hff, 1'b1);
    chk(8'(port_mode), 8'(SSHP_OFF), "off frame");
  endtask
  // *********
  // main sequence
  // *********
  initial begin
    reset_n = 1'b0;
    pending_disable = 1'b0;
    full_enable = 1'b0;
    uart_cmd_seen = 1'b0;
    rx_busy = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    cyc(16);
    reset_n = 1'b1;
    t_detect();
    t_data(1'b0, 8'h3c);
    t_data(1'b1, 8'hc5);
    t_flags();
    t_uart();
    end_sim();
  end
endmodule
`default_nettype wire
